// File: common/rmcr_pkg.sv
// rmcr_pkg: register map, field positions, reset values and codes
// for the radio misc control register bank.
// assumes 8-bit registers, one per 32-bit wishbone word.
package rmcr_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_PIN_VALUE   = 8'h33;
    localparam logic [7:0] IDX_PIN_DIR     = 8'h34;
    localparam logic [7:0] IDX_SLEEP_WAKE  = 8'h35;
    localparam logic [7:0] IDX_RF_MODE     = 8'h36;
    localparam logic [7:0] IDX_SEC_CTRL2   = 8'h37;
    localparam logic [7:0] IDX_BB_ZERO     = 8'h38;
    localparam logic [7:0] IDX_SEC_STATUS  = 8'h40;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int NUM_PINS          = 6;
    localparam int BIT_SLEEP_CMD     = 7;
    localparam int BIT_WAKE_HI_LSB   = 3;
    localparam int BIT_RF_RESET      = 2;
    localparam int BIT_FORCE_TX      = 1;
    localparam int BIT_FORCE_RX      = 0;
    localparam int BIT_UP_DECRYPT    = 7;
    localparam int BIT_UP_ENCRYPT    = 6;
    localparam int SLOT2_CIPHER_LSB  = 3;
    localparam int SLOT1_CIPHER_LSB  = 0;
    localparam int BIT_FAST_RATE     = 0;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [5:0] RST_PIN       = 6'h00;
    localparam logic [8:0] RST_WAKE_CNT  = 9'h000;
    localparam logic [8:0] REC_WAKE_CNT  = 9'h05f;
    localparam logic [2:0] RST_CIPHER    = 3'h0;

    // ----------------------------------------------------------------
    // cipher suite codes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        RMCR_CIPH_NONE       = 3'h0,
        RMCR_CIPH_CTR        = 3'h1,
        RMCR_CIPH_CCM_128    = 3'h2,
        RMCR_CIPH_CCM_64     = 3'h3,
        RMCR_CIPH_CCM_32     = 3'h4,
        RMCR_CIPH_CBCMAC_128 = 3'h5,
        RMCR_CIPH_CBCMAC_64  = 3'h6,
        RMCR_CIPH_CBCMAC_32  = 3'h7
    } rmcr_cipher_t;

endpackage

// File: src/rmcr_pin_cell.sv
// rmcr_pin_cell: one general-purpose pin, direction and value.
// assumes pin input synchronous to clk_i.
`timescale 1ns/1ps
module rmcr_pin_cell
    import rmcr_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic wr_i,
    input  wire logic val_d_i,
    input  wire logic dir_d_i,
    input  wire logic pin_i,
    output logic      pin_o,
    output logic      pin_oe_o,
    output logic      rd_val_o,
    output logic      dir_o
);

    typedef struct packed {
        logic val;
        logic dir;
        logic pin_q;
    } rmcr_pin_state_t;

    rmcr_pin_state_t st;
    rmcr_pin_state_t next_st;

    always_comb begin
        next_st       = st;
        next_st.pin_q = pin_i;
        if (wr_i) begin
            next_st.val = val_d_i;
            next_st.dir = dir_d_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // RULE16: drive or sample
    assign pin_o    = st.val;
    // RULE2: one means output
    assign pin_oe_o = st.dir;
    assign rd_val_o = st.dir ? st.val : st.pin_q;
    assign dir_o    = st.dir;

endmodule

// File: src/rmcr_regs.sv
// rmcr_regs: radio misc control register bank on a classic wishbone slave.
// assumes wishbone master holds request until ack; crypto engine, sleep
// controller and rf state machine sit outside, only the crypto engine answers with done pulses.
// Behaviour
// RULE1: pin value register holds six pin bits in 5..0, bits 7..6 reserved.
// RULE2: each pin direction bit makes its pin an output when one, input when zero (reset).
// RULE3: writing one to the sleep command bit sleeps the device and the bit self-clears.
// RULE4: the nine-bit wake count is split, bits 6..0 in sleep/wake and 8..7 in mode bits 4..3.
// RULE5: wake count times oscillator start-up in sleep clocks, resets to zero.
// RULE6: rf reset bit one holds the rf state machine in reset, zero lets it run.
// RULE7: software pulses rf reset then waits at least 192 us for calibration.
// RULE8: mode bit 1 forces transmit state, bit 0 forces receive state.
// RULE9: software writes 0x06 then 0x02 to reset and then transmit.
// RULE10: writing one to decrypt bit 7 starts upper-layer decryption, cleared when done.
// RULE11: writing one to encrypt bit 6 starts upper-layer encryption, cleared when done.
// RULE12: second slot cipher field 5..3 selects the suite, zero meaning none.
// RULE13: first slot cipher field 2..0 uses the same encoding, zero by default.
// RULE14: baseband zero bit 0 picks 625 kbps when one, 250 kbps when zero.
// RULE15: software keeps reserved bits at zero.
// RULE16: an output pin is driven from its value bit, an input pin reads its level.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
module rmcr_regs
    import rmcr_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // wishbone slave
    input  wire logic                 cyc_i,
    input  wire logic                 stb_i,
    input  wire logic                 we_i,
    input  wire logic [3:0]           sel_i,
    input  wire logic [9:0]           adr_i,
    input  wire logic [31:0]          dat_i,
    output logic      [31:0]          dat_o,
    output logic                      ack_o,
    // general-purpose pins
    input  wire logic [NUM_PINS-1:0]  pin_i,
    output logic      [NUM_PINS-1:0]  pin_o,
    output logic      [NUM_PINS-1:0]  pin_oe_o,
    // sleep and wake
    output logic                      sleep_go_o,
    output logic      [8:0]           wake_count_o,
    // rf state machine
    output logic                      rf_sm_reset_o,
    output logic                      force_transmit_o,
    output logic                      force_receive_o,
    // upper-layer security
    output logic                      upper_decrypt_go_o,
    output logic                      upper_encrypt_go_o,
    input  wire logic                 upper_decrypt_done_i,
    input  wire logic                 upper_encrypt_done_i,
    output logic      [2:0]           slot2_cipher_sel_o,
    output logic      [2:0]           slot1_cipher_sel_o,
    // baseband
    output logic                      fast_rate_o
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        ack;
        logic [7:0]  rdata;
        logic        sleep_go;
        logic [8:0]  wake_cnt;
        logic        rf_rst;
        logic        f_tx;
        logic        f_rx;
        logic        dec_go;
        logic        enc_go;
        logic [2:0]  c2;
        logic [2:0]  c1;
        logic        fast;
        logic        dec_seen;
        logic        enc_seen;
    } rmcr_state_t;

    rmcr_state_t st;
    rmcr_state_t next_st;

    logic                req;
    logic                wr_lane0;
    logic [7:0]          idx;
    logic [7:0]          wbyte;
    logic                pin_wr;
    logic [NUM_PINS-1:0] rd_val;
    logic [NUM_PINS-1:0] dir_q;
    logic [NUM_PINS-1:0] pin_out;
    logic [NUM_PINS-1:0] pin_oe;
    logic [NUM_PINS-1:0] val_d;
    logic [NUM_PINS-1:0] dir_d;
    // write fields
    logic                w_sleep;
    logic [6:0]          w_wake_lo;
    logic [1:0]          w_wake_hi;
    logic                w_rf_rst;
    logic                w_f_tx;
    logic                w_f_rx;
    logic                w_dec;
    logic                w_enc;
    logic [2:0]          w_c2;
    logic [2:0]          w_c1;
    logic                w_fast;
    // read bytes
    logic [7:0]          rd_pin_value;
    logic [7:0]          rd_pin_dir;
    logic [7:0]          rd_sleep_wake;
    logic [7:0]          rd_rf_mode;
    logic [7:0]          rd_sec_ctrl2;
    logic [7:0]          rd_bb_zero;
    logic [7:0]          rd_sec_status;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    // one wait state; ack drops the cycle after it is given
    assign req      = cyc_i && stb_i && !st.ack;
    assign idx      = adr_i[9:2];
    assign wbyte    = dat_i[7:0];
    assign wr_lane0 = req && we_i && sel_i[0];
    // value and direction written separately, other half kept
    assign pin_wr   = wr_lane0 && (idx == IDX_PIN_VALUE || idx == IDX_PIN_DIR);

    // ----------------------------------------------------------------
    // pins
    // ----------------------------------------------------------------
    // the half of the pair not addressed keeps its stored value
    assign val_d = (idx == IDX_PIN_VALUE) ? wbyte[NUM_PINS-1:0] : pin_out;
    assign dir_d = (idx == IDX_PIN_DIR) ? wbyte[NUM_PINS-1:0] : dir_q;
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            // RULE1: one cell per pin
            rmcr_pin_cell u_cell (
                .clk_i    (clk_i),
                .rst_i    (rst_i),
                .wr_i     (pin_wr),
                .val_d_i  (val_d[g]),
                .dir_d_i  (dir_d[g]),
                .pin_i    (pin_i[g]),
                .pin_o    (pin_out[g]),
                .pin_oe_o (pin_oe[g]),
                .rd_val_o (rd_val[g]),
                .dir_o    (dir_q[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // write fields
    // ----------------------------------------------------------------
    // reserved bits feed no field, so they are dropped and read as zero
    assign w_sleep   = wbyte[BIT_SLEEP_CMD];
    assign w_wake_lo = wbyte[6:0];
    assign w_wake_hi = wbyte[BIT_WAKE_HI_LSB +: 2];
    assign w_rf_rst  = wbyte[BIT_RF_RESET];
    assign w_f_tx    = wbyte[BIT_FORCE_TX];
    assign w_f_rx    = wbyte[BIT_FORCE_RX];
    assign w_dec     = wbyte[BIT_UP_DECRYPT];
    assign w_enc     = wbyte[BIT_UP_ENCRYPT];
    assign w_c2      = wbyte[SLOT2_CIPHER_LSB +: 3];
    assign w_c1      = wbyte[SLOT1_CIPHER_LSB +: 3];
    assign w_fast    = wbyte[BIT_FAST_RATE];

    // ----------------------------------------------------------------
    // read bytes
    // ----------------------------------------------------------------
    // RULE16: stored bit or sampled level
    assign rd_pin_value  = {2'b00, rd_val};
    assign rd_pin_dir    = {2'b00, dir_q};
    // command bit reads zero, it never stays set
    assign rd_sleep_wake = {1'b0, st.wake_cnt[6:0]};
    assign rd_rf_mode    = {3'b000, st.wake_cnt[8:7], st.rf_rst, st.f_tx, st.f_rx};
    assign rd_sec_ctrl2  = {st.dec_go, st.enc_go, st.c2, st.c1};
    assign rd_bb_zero    = {7'h00, st.fast};
    assign rd_sec_status = {6'h00, st.dec_seen, st.enc_seen};

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st       = st;
        next_st.ack   = req;
        // RULE3: sleep command is a pulse
        next_st.sleep_go = 1'b0;
        // RULE10: decrypt bit clears on done
        if (upper_decrypt_done_i) begin
            next_st.dec_go   = 1'b0;
            next_st.dec_seen = 1'b1;
        end
        // RULE11: encrypt bit clears on done
        if (upper_encrypt_done_i) begin
            next_st.enc_go   = 1'b0;
            next_st.enc_seen = 1'b1;
        end
        if (wr_lane0) begin
            case (idx)
                IDX_SLEEP_WAKE: begin
                    next_st.sleep_go      = w_sleep;
                    // RULE4: low seven wake bits
                    next_st.wake_cnt[6:0] = w_wake_lo;
                end
                IDX_RF_MODE: begin
                    // RULE4: top two wake bits
                    next_st.wake_cnt[8:7] = w_wake_hi;
                    // RULE6: hold rf in reset
                    next_st.rf_rst = w_rf_rst;
                    // RULE8: forced tx and rx
                    next_st.f_tx   = w_f_tx;
                    next_st.f_rx   = w_f_rx;
                end
                IDX_SEC_CTRL2: begin
                    // a fresh start wins over a done in the same cycle
                    if (w_dec) begin
                        next_st.dec_go = 1'b1;
                    end
                    if (w_enc) begin
                        next_st.enc_go = 1'b1;
                    end
                    // RULE12: second slot suite
                    next_st.c2 = w_c2;
                    // RULE13: first slot suite
                    next_st.c1 = w_c1;
                end
                IDX_BB_ZERO: begin
                    // RULE14: rate select
                    next_st.fast = w_fast;
                end
                IDX_SEC_STATUS: begin
                    // write one to clear; a done in this cycle wins
                    if (wbyte[1] && !upper_decrypt_done_i) begin
                        next_st.dec_seen = 1'b0;
                    end
                    if (wbyte[0] && !upper_encrypt_done_i) begin
                        next_st.enc_seen = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        next_st.rdata = 8'h00;
        if (req && !we_i) begin
            case (idx)
                IDX_PIN_VALUE:  next_st.rdata = rd_pin_value;
                IDX_PIN_DIR:    next_st.rdata = rd_pin_dir;
                IDX_SLEEP_WAKE: next_st.rdata = rd_sleep_wake;
                IDX_RF_MODE:    next_st.rdata = rd_rf_mode;
                IDX_SEC_CTRL2:  next_st.rdata = rd_sec_ctrl2;
                IDX_BB_ZERO:    next_st.rdata = rd_bb_zero;
                IDX_SEC_STATUS: next_st.rdata = rd_sec_status;
                default:        next_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // RULE5: wake count starts at zero
            st.ack      <= 1'b0;
            st.rdata    <= 8'h00;
            st.sleep_go <= 1'b0;
            st.wake_cnt <= RST_WAKE_CNT;
            st.rf_rst   <= 1'b0;
            st.f_tx     <= 1'b0;
            st.f_rx     <= 1'b0;
            st.dec_go   <= 1'b0;
            st.enc_go   <= 1'b0;
            st.c2       <= RST_CIPHER;
            st.c1       <= RST_CIPHER;
            st.fast     <= 1'b0;
            st.dec_seen <= 1'b0;
            st.enc_seen <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // bus
    assign ack_o              = st.ack;
    assign dat_o              = {24'h000000, st.rdata};
    // pins
    assign pin_o              = pin_out;
    // RULE2: one means driving
    assign pin_oe_o           = pin_oe;
    // control levels and pulses
    assign sleep_go_o         = st.sleep_go;
    assign wake_count_o       = st.wake_cnt;
    assign rf_sm_reset_o      = st.rf_rst;
    assign force_transmit_o   = st.f_tx;
    assign force_receive_o    = st.f_rx;
    assign upper_decrypt_go_o = st.dec_go;
    assign upper_encrypt_go_o = st.enc_go;
    assign slot2_cipher_sel_o = st.c2;
    assign slot1_cipher_sel_o = st.c1;
    assign fast_rate_o        = st.fast;

endmodule

// File: testbench/rmcr_regs_assertions.sv
// rmcr_regs_assertions: port-level checks of the register bank.
// assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module rmcr_regs_assertions
    import rmcr_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [9:0]  adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        sleep_go_o,
    input wire logic [8:0]  wake_count_o,
    input wire logic        rf_sm_reset_o,
    input wire logic        force_transmit_o,
    input wire logic        force_receive_o,
    input wire logic        upper_decrypt_go_o,
    input wire logic        upper_encrypt_go_o,
    input wire logic        upper_decrypt_done_i,
    input wire logic        upper_encrypt_done_i,
    input wire logic        fast_rate_o
);
    logic [7:0] idx;
    logic       rd;
    assign idx = adr_i[9:2];
    assign rd  = ack_o && !we_i;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack one cycle after request");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_sleep_pulse: assert property (sleep_go_o |=> !sleep_go_o)
        else $error("sleep command did not self clear");
    a_sleep_cause: assert property (sleep_go_o |->
        $past(cyc_i && we_i && dat_i[7]) && $past(idx) == IDX_SLEEP_WAKE)
        else $error("sleep pulse without sleep write");
    a_dec_clear: assert property ($fell(upper_decrypt_go_o) |-> $past(upper_decrypt_done_i))
        else $error("decrypt start cleared without done");
    a_enc_clear: assert property ($fell(upper_encrypt_go_o) |-> $past(upper_encrypt_done_i))
        else $error("encrypt start cleared without done");
    a_read_mode: assert property (rd && idx == IDX_RF_MODE |-> dat_o[7:0] ==
        {3'h0, wake_count_o[8:7], rf_sm_reset_o, force_transmit_o, force_receive_o})
        else $error("mode read differs from outputs");
    a_read_sleep: assert property (rd && idx == IDX_SLEEP_WAKE |->
        dat_o[7:0] == {1'b0, wake_count_o[6:0]})
        else $error("sleep read differs from wake count");
    a_read_rate: assert property (rd && idx == IDX_BB_ZERO |-> dat_o[7:0] == {7'h00, fast_rate_o})
        else $error("rate read differs from output");
endmodule

bind rmcr_regs rmcr_regs_assertions i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .sleep_go_o(sleep_go_o), .wake_count_o(wake_count_o), .rf_sm_reset_o(rf_sm_reset_o),
    .force_transmit_o(force_transmit_o), .force_receive_o(force_receive_o),
    .upper_decrypt_go_o(upper_decrypt_go_o), .upper_encrypt_go_o(upper_encrypt_go_o),
    .upper_decrypt_done_i(upper_decrypt_done_i), .upper_encrypt_done_i(upper_encrypt_done_i),
    .fast_rate_o(fast_rate_o));

// File: testbench/rmcr_regs_tb.sv
// rmcr_regs_tb: self-checking bench for the register bank.
// assumes the checker is bound in from its own file.
`timescale 1ns/1ps
module rmcr_regs_tb import rmcr_pkg::*;;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, dec_done, enc_done, ack_o;
    logic        sleep_go_o, rf_rst, f_tx, f_rx, dec_go, enc_go, fast_rate_o;
    logic [3:0]  sel_i;
    logic [9:0]  adr_i;
    logic [31:0] dat_i, dat_o;
    logic [5:0]  pin_i, pin_o, pin_oe_o, d, v, p;
    logic [8:0]  wake_count_o, w;
    logic [2:0]  s2, s1, m;
    logic [7:0]  exp_q[$];
    int          n_errors, check_count, n_sleep;
    // calibration wait after an rf reset, 192 us at 100 ns
    localparam int CAL_WAIT = 1920;

    rmcr_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .sleep_go_o(sleep_go_o),
        .wake_count_o(wake_count_o), .rf_sm_reset_o(rf_rst), .force_transmit_o(f_tx),
        .force_receive_o(f_rx), .upper_decrypt_go_o(dec_go), .upper_encrypt_go_o(enc_go),
        .upper_decrypt_done_i(dec_done), .upper_encrypt_done_i(enc_done),
        .slot2_cipher_sel_o(s2), .slot1_cipher_sel_o(s1), .fast_rate_o(fast_rate_o));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task end_of_test;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input logic [8:0] got, input logic [8:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle; for a read, d8 is the expected byte
    task wb(input logic wr, input logic [7:0] idx, input logic [7:0] d8);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= wr;
        adr_i <= {idx, 2'($urandom)};
        dat_i <= {24'($urandom), d8};
        if (!wr)
            exp_q.push_back(d8);
        // request stands until ack is seen at a rising edge
        do @(posedge clk_i); while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(negedge clk_i);
    endtask

    task pulse_done(input logic dec);
        @(posedge clk_i);
        dec_done <= dec;
        enc_done <= !dec;
        @(posedge clk_i);
        dec_done <= 1'b0;
        enc_done <= 1'b0;
        @(negedge clk_i);
    endtask

    always @(negedge clk_i) begin
        if (sleep_go_o === 1'b1)
            n_sleep++;
        if (ack_o === 1'b1 && we_i === 1'b0)
            chk(9'(dat_o[7:0]), 9'(exp_q.pop_front()));
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        $display("mismatch at %0t: timeout", $time);
        end_of_test();
    end

    initial begin
        {cyc_i, stb_i, we_i, dec_done, enc_done, adr_i, dat_i, pin_i} = '0;
        sel_i = 4'hf;
        rst_i = 1'b1;
        void'($urandom(38116));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 8'h33; i <= 8'h38; i++) wb(1'b0, 8'(i), 8'h00);
        chk(9'(pin_oe_o), 9'h000);
        chk(wake_count_o, RST_WAKE_CNT);
        chk(9'({s2, s1}), 9'({RST_CIPHER, RST_CIPHER}));
        for (int i = 0; i < 4; i++) begin
            {d, v, p} = 18'($urandom);
            wb(1'b1, IDX_PIN_DIR, {2'h0, d});
            wb(1'b1, IDX_PIN_VALUE, {2'h0, v});
            chk(9'(pin_oe_o), 9'(d));
            chk(9'(pin_o), 9'(v));
            @(posedge clk_i);
            pin_i <= p;
            wb(1'b0, IDX_PIN_DIR, {2'h0, d});
            wb(1'b0, IDX_PIN_VALUE, {2'h0, (d & v) | (~d & p)});
            w = (i == 0) ? REC_WAKE_CNT : 9'($urandom);
            wb(1'b1, IDX_SLEEP_WAKE, {1'b0, w[6:0]});
            wb(1'b1, IDX_RF_MODE, {3'h0, w[8:7], 3'h0});
            chk(wake_count_o, w);
        end
        wb(1'b1, IDX_SLEEP_WAKE, {1'b1, w[6:0]});
        repeat (3) @(posedge clk_i);
        chk(9'(n_sleep), 9'h001);
        wb(1'b0, IDX_SLEEP_WAKE, {1'b0, w[6:0]});
        chk(wake_count_o, w);
        wb(1'b1, IDX_RF_MODE, {3'h0, w[8:7], 3'h4});
        chk(9'(rf_rst), 9'h001);
        wb(1'b1, IDX_RF_MODE, {3'h0, w[8:7], 3'h0});
        chk(9'(rf_rst), 9'h000);
        repeat (CAL_WAIT) @(posedge clk_i);
        for (int k = 0; k < 5; k++) begin
            m = k == 0 ? 3'h6 : k == 1 ? 3'h2 : k == 2 ? 3'h1 : k == 3 ? 3'h4 : 3'h0;
            wb(1'b1, IDX_RF_MODE, {3'h0, w[8:7], m});
            chk(9'({rf_rst, f_tx, f_rx}), 9'(m));
        end
        for (int c = 0; c < 8; c++) begin
            wb(1'b1, IDX_SEC_CTRL2, {2'h0, 3'(c), 3'(7 - c)});
            chk(9'({s2, s1}), 9'({3'(c), 3'(7 - c)}));
        end
        wb(1'b1, IDX_SEC_CTRL2, 8'hc0);
        repeat (4) @(posedge clk_i);
        chk(9'({dec_go, enc_go}), 9'h003);
        pulse_done(1'b1);
        chk(9'({dec_go, enc_go}), 9'h001);
        pulse_done(1'b0);
        chk(9'({dec_go, enc_go}), 9'h000);
        wb(1'b0, IDX_SEC_STATUS, 8'h03);
        // clear both flags while a decrypt done lands: that flag stays
        fork
            wb(1'b1, IDX_SEC_STATUS, 8'h03);
            pulse_done(1'b1);
        join
        wb(1'b0, IDX_SEC_STATUS, 8'h02);
        wb(1'b1, IDX_SEC_STATUS, 8'h02);
        wb(1'b0, IDX_SEC_STATUS, 8'h00);
        // a fresh start in the cycle of a done keeps the start bit
        fork
            wb(1'b1, IDX_SEC_CTRL2, 8'h80);
            pulse_done(1'b1);
        join
        chk(9'({dec_go, enc_go}), 9'h002);
        pulse_done(1'b1);
        chk(9'({dec_go, enc_go}), 9'h000);
        for (int b = 1; b >= 0; b--) begin
            wb(1'b1, IDX_BB_ZERO, {7'h00, 1'(b)});
            chk(9'(fast_rate_o), 9'(b));
            wb(1'b0, IDX_BB_ZERO, {7'h00, 1'(b)});
        end
        wb(1'b1, IDX_PIN_DIR, 8'h3f);
        wb(1'b1, IDX_SLEEP_WAKE, {1'b0, REC_WAKE_CNT[6:0]});
        // mid-run reset brings the bank back to its reset values
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk(wake_count_o, RST_WAKE_CNT);
        chk(9'(pin_oe_o), 9'h000);
        wb(1'b1, 8'h3f, 8'hff);
        wb(1'b0, 8'h3f, 8'h00);
        repeat (3) @(posedge clk_i);
        chk(9'(exp_q.size()), 9'h000);
        end_of_test();
    end
endmodule
